// file: src/software_trace_debug_port.sv
// Behaviour
// RULE_01: PC trace instruction emits one record holding the current PC.
// RULE_02: Tag instruction emits 10-bit immediate record, PC optionally appended.
// RULE_03: Register instruction emits number and value per register ascending, PC optional.
// RULE_04: Records pass through internal trace buffer, then go out on link.
// RULE_05: Without an attached probe, trace instructions transmit nothing.
// RULE_06: Each record holds the link for its fixed time per type and link.
// RULE_07: Buffer absorbs bursts; records lost with overflow only when buffer full.
// RULE_08: Software spaces trace instructions by at least the record transmit time.
// RULE_09: Software names fewer than five registers per register trace instruction.
// RULE_10: Debug-interface select field sits at bits 17 and 16 of option word.
// RULE_11: With probe attached the field reads 01B on 4-wire, 10B on 1-wire.
// RULE_12: Neither debugger nor self-programming writes the select bits.
// RULE_13: Probe timestamps records on receipt and starts counting before run.
// RULE_14: Probe avoids run-time memory access and polling while tracing.
// RULE_15: Without tracing, breaks ignored 10 us after start, 100 us on slow oscillator.
// RULE_16: Measured-time resolution follows link type and rate.
// RULE_17: User programs contain no break trap instruction while probe attached.
// RULE_18: Probe connection clears local RAM and flash-control RAM to zero.
// RULE_19: Records leave in execution order, first in, first out.
`default_nettype none
module software_trace_debug_port
    import swtrace_pkg::*;
#(
    parameter int BLANK_FAST = swtrace_pkg::BLANK_FAST_CYC, // Short blanking, cycles.
    parameter int BLANK_SLOW = swtrace_pkg::BLANK_SLOW_CYC, // Long blanking, cycles.
    parameter int LONG_4     = swtrace_pkg::CYC_4_LONG,     // 4-wire long record.
    parameter int SHORT_4    = swtrace_pkg::CYC_4_SHORT,    // 4-wire tag record.
    parameter int LONG_1     = swtrace_pkg::CYC_1_LONG,     // 1-wire long record.
    parameter int SHORT_1    = swtrace_pkg::CYC_1_SHORT     // 1-wire tag record.
) (
    input  wire logic                    clk,          // 250 MHz clock.
    input  wire logic                    rst_n,        // Synchronous reset, low.
    input  wire logic                    probe_on,     // Probe attached.
    input  wire logic                    link_1wire,   // 1-wire link chosen.
    input  wire logic                    slow_internal_osc, // Debug logic on slow osc.
    input  wire logic                    trace_used,   // Trace output in use.
    input  wire logic                    insn_valid,   // Trace instruction issued.
    input  wire swtrace_pkg::insn_type   insn,         // Instruction fields.
    input  wire logic [DATA_W-1:0]       gpr_value,    // Value of gpr_index.
    input  wire logic                    prog_start,   // Program starts running.
    input  wire logic                    break_req,    // Raw break request.
    output logic                         insn_ready,   // Can take instruction.
    output logic [REGN_W-1:0]            gpr_index,    // Register being read.
    output logic                         link_valid,   // Record on link.
    output swtrace_pkg::record_type      link_rec,     // Record being sent.
    output logic                         link_done,    // Record time elapsed.
    output logic                         overflow,     // Record lost.
    output logic [SEL_MSB:SEL_LSB]       debug_if_sel, // Option word select field.
    output logic                         break_out,    // Accepted break.
    output logic                         ram_we,       // RAM clear write.
    output logic [RAM_AW-1:0]            ram_addr,     // RAM clear address.
    output logic [31:0]                  ram_wdata     // RAM clear data.
);
    import swtrace_pkg::*;

    typedef enum {ST_IDLE, ST_MAIN, ST_REGS, ST_PC} gen_state_type;

    gen_state_type       st_r;
    insn_type            cur_r;
    logic [REGN_W-1:0]   idx_r;
    record_type          gen_rec;
    logic                gen_valid;
    logic                gen_ready;
    record_type          buf_mem_r [BUF_DEPTH];
    logic [BUF_AW:0]     wp_r;
    logic [BUF_AW:0]     rp_r;
    logic                buf_full;
    logic                buf_empty;
    logic [CNT_W-1:0]    tx_cnt_r;
    logic [CNT_W-1:0]    rec_time;
    logic [CNT_W-1:0]    blank_r;
    logic                probe_d_r;
    logic [RAM_AW:0]     clr_r;
    logic                overflow_r;

    // Record from the generator in its current state.
    always_comb begin
        gen_valid      = 1'b0;
        gen_rec        = '0;
        gen_rec.kind   = REC_PC;
        gen_rec.value  = cur_r.pc;
        case (st_r)
            ST_MAIN: begin
                gen_valid = 1'b1;
                if (cur_r.kind == INSN_TAG) begin
                    gen_rec.kind  = REC_TAG; // RULE_02
                    gen_rec.value = {{(DATA_W-TAG_W){1'b0}}, cur_r.tag};
                end else begin
                    gen_rec.kind  = REC_PC; // RULE_01
                end
            end
            ST_REGS: begin
                gen_valid      = 1'b1;
                gen_rec.kind   = REC_REG; // RULE_03
                gen_rec.regnum = idx_r;
                gen_rec.value  = gpr_value;
            end
            ST_PC: begin
                gen_valid = 1'b1;
            end
            default: begin
                gen_valid = 1'b0;
            end
        endcase
    end

    // A full buffer drops the record rather than stall the CPU.
    assign gen_ready = 1'b1;
    assign buf_full  = (wp_r[BUF_AW] != rp_r[BUF_AW]) && (wp_r[BUF_AW-1:0] == rp_r[BUF_AW-1:0]);
    assign buf_empty = (wp_r == rp_r);

    // Generator walks one instruction into its records; nothing starts without a probe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r  <= ST_IDLE;
            cur_r <= '0;
            idx_r <= '0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (insn_valid && probe_on && insn.kind != INSN_NONE) begin // RULE_05
                        cur_r <= insn;
                        idx_r <= insn.reg_lo;
                        st_r  <= (insn.kind == INSN_REG) ? ST_REGS : ST_MAIN;
                    end
                end
                ST_MAIN: begin
                    st_r <= (cur_r.kind == INSN_TAG && cur_r.with_pc) ? ST_PC : ST_IDLE; // RULE_02
                end
                ST_REGS: begin
                    if (idx_r == cur_r.reg_hi) begin // RULE_03
                        st_r <= cur_r.with_pc ? ST_PC : ST_IDLE;
                    end else begin
                        idx_r <= idx_r + 1'b1;
                    end
                end
                ST_PC: begin
                    st_r <= ST_IDLE;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Two-entry margin is exceeded here: eight stages of flip-flops absorb bursts.
    generate
        for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    buf_mem_r[i] <= '0;
                end else if (gen_valid && !buf_full && wp_r[BUF_AW-1:0] == BUF_AW'(i)) begin
                    buf_mem_r[i] <= gen_rec; // RULE_04
                end
            end
        end
    endgenerate

    // Pointers; oldest entry always leaves first.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (gen_valid && !buf_full) begin
                wp_r <= wp_r + 1'b1; // RULE_19
            end
            if (link_done) begin
                rp_r <= rp_r + 1'b1; // RULE_19
            end
        end
    end

    // Overflow pulses only when a record meets a full buffer.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_r <= 1'b0;
        end else begin
            overflow_r <= gen_valid && buf_full; // RULE_07
        end
    end
    assign overflow = overflow_r;

    // Record time by kind and link.
    always_comb begin
        if (link_1wire) begin
            rec_time = (buf_mem_r[rp_r[BUF_AW-1:0]].kind == REC_TAG) ?
                       CNT_W'(SHORT_1) : CNT_W'(LONG_1);
        end else begin
            rec_time = (buf_mem_r[rp_r[BUF_AW-1:0]].kind == REC_TAG) ?
                       CNT_W'(SHORT_4) : CNT_W'(LONG_4);
        end
    end

    // Link sender holds each record for its fixed time.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_valid <= 1'b0;
            link_rec   <= '0;
            link_done  <= 1'b0;
            tx_cnt_r   <= '0;
        end else begin
            link_done <= 1'b0;
            if (link_valid) begin
                if (tx_cnt_r == CNT_W'(1)) begin
                    link_valid <= 1'b0;
                    link_done  <= 1'b1; // RULE_06
                end else begin
                    tx_cnt_r <= tx_cnt_r - 1'b1;
                end
            end else if (!buf_empty && !link_done && probe_on) begin
                link_valid <= 1'b1; // RULE_04
                link_rec   <= buf_mem_r[rp_r[BUF_AW-1:0]];
                tx_cnt_r   <= rec_time; // RULE_06
            end
        end
    end

    // Select field reflects the link while the probe is attached.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            debug_if_sel <= SEL_NONE;
        end else if (probe_on) begin
            debug_if_sel <= link_1wire ? SEL_1WIRE : SEL_4WIRE; // RULE_10 RULE_11
        end
    end

    // Break blanking after program start when tracing is off.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blank_r   <= '0;
            break_out <= 1'b0;
        end else begin
            if (prog_start && !trace_used) begin
                blank_r <= slow_internal_osc ? CNT_W'(BLANK_SLOW) : CNT_W'(BLANK_FAST); // RULE_15
            end else if (blank_r != '0) begin
                blank_r <= blank_r - 1'b1;
            end
            break_out <= break_req && (blank_r == '0) && !prog_start; // RULE_15
        end
    end

    // RAM clear sweep starts on probe attach; zero is written to every word.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            probe_d_r <= 1'b0;
            clr_r     <= '0;
            ram_we    <= 1'b0;
            ram_addr  <= '0;
            ram_wdata <= RAM_CLEAR;
        end else begin
            probe_d_r <= probe_on;
            ram_we    <= 1'b0;
            if (probe_on && !probe_d_r) begin
                clr_r <= {1'b1, {RAM_AW{1'b0}}}; // RULE_18
            end else if (clr_r[RAM_AW]) begin
                ram_we    <= 1'b1; // RULE_18
                ram_addr  <= clr_r[RAM_AW-1:0];
                ram_wdata <= RAM_CLEAR;
                clr_r     <= (clr_r[RAM_AW-1:0] == {RAM_AW{1'b1}}) ? '0 : clr_r + 1'b1;
            end
        end
    end

    // Issue only when idle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            insn_ready <= 1'b0;
        end else begin
            insn_ready <= (st_r == ST_IDLE) && !(insn_valid && probe_on) && gen_ready;
        end
    end

    // The index is the walk register itself, so the value read back belongs to the
    // register that the record names; a delayed copy would pair it with the previous one.
    assign gpr_index = idx_r; // RULE_03

    chk_ovf_full: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        gen_valid && !buf_full |=> !overflow)
        else $error("overflow without full buffer");
    chk_ovf_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        gen_valid && buf_full |=> overflow)
        else $error("lost record not flagged");
    chk_no_probe: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        st_r == ST_IDLE && !probe_on |=> st_r == ST_IDLE)
        else $error("record made without probe");
    chk_sel_4w: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        probe_on && !link_1wire |=> debug_if_sel == SEL_4WIRE)
        else $error("select field wrong on 4-wire");
    chk_sel_1w: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        probe_on && link_1wire |=> debug_if_sel == SEL_1WIRE)
        else $error("select field wrong on 1-wire");
    chk_fifo_order: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
        link_done |=> rp_r == $past(rp_r) + 1'b1)
        else $error("read pointer skipped");
    chk_tx_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
        $rose(link_valid) |-> tx_cnt_r == $past(rec_time))
        else $error("record time not loaded");
    chk_reg_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        st_r == ST_REGS && idx_r != cur_r.reg_hi |=> idx_r == $past(idx_r) + 1'b1)
        else $error("register walk not ascending");
    chk_blank: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
        prog_start && !trace_used |=> ##[0:2] !break_out)
        else $error("break during blanking");
    chk_ram_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
        ram_we |-> ram_wdata == RAM_CLEAR)
        else $error("ram clear not zero");

endmodule : software_trace_debug_port
`default_nettype wire

// file: src/swtrace_pkg.sv
`default_nettype none
package swtrace_pkg;

    // Instruction kinds; all but INSN_NONE produce trace records.
    typedef enum logic [1:0] {
        INSN_NONE,
        INSN_PC,
        INSN_TAG,
        INSN_REG
    } insn_kind_type;

    // Link in use, as reported in the option word select field.
    localparam logic [1:0] SEL_4WIRE = 2'h1;
    localparam logic [1:0] SEL_1WIRE = 2'h2;
    localparam logic [1:0] SEL_NONE  = 2'h3;
    localparam int         SEL_LSB   = 16;
    localparam int         SEL_MSB   = 17;

    localparam int TAG_W    = 10;
    localparam int DATA_W   = 32;
    localparam int REGN_W   = 5;
    localparam int BUF_DEPTH = 8;
    localparam int BUF_AW   = 3;

    // Record kinds carried on the link.
    typedef enum logic [1:0] {
        REC_PC,
        REC_TAG,
        REC_REG
    } rec_kind_type;

    // One trace record.
    typedef struct packed {
        rec_kind_type        kind;
        logic [REGN_W-1:0]   regnum;
        logic [DATA_W-1:0]   value;
    } record_type;

    // One trace instruction issued by the CPU.
    typedef struct packed {
        insn_kind_type       kind;
        logic                with_pc;
        logic [TAG_W-1:0]    tag;
        logic [REGN_W-1:0]   reg_lo;
        logic [REGN_W-1:0]   reg_hi;
        logic [DATA_W-1:0]   pc;
    } insn_type;

    // Clock rate and per-record link times.
    localparam int CLK_MHZ      = 250;
    localparam int T4_LONG_PS   = 1727000;
    localparam int T4_SHORT_PS  = 576000;
    localparam int T1_LONG_PS   = 28500000;
    localparam int T1_SHORT_PS  = 9500000;
    localparam int PS_PER_CYC   = 1000000 / CLK_MHZ;
    localparam int CYC_4_LONG   = T4_LONG_PS / PS_PER_CYC;
    localparam int CYC_4_SHORT  = T4_SHORT_PS / PS_PER_CYC;
    localparam int CYC_1_LONG   = T1_LONG_PS / PS_PER_CYC;
    localparam int CYC_1_SHORT  = T1_SHORT_PS / PS_PER_CYC;

    // Break blanking after program start.
    localparam int BLANK_FAST_US = 10;
    localparam int BLANK_SLOW_US = 100;
    localparam int BLANK_FAST_CYC = BLANK_FAST_US * CLK_MHZ;
    localparam int BLANK_SLOW_CYC = BLANK_SLOW_US * CLK_MHZ;

    // RAM clear.
    localparam int          RAM_AW    = 12;
    localparam logic [31:0] RAM_CLEAR = 32'h0000_0000;

    localparam int CNT_W = 24;

endpackage : swtrace_pkg
`default_nettype wire

// file: testbench/probe_model.sv
`default_nettype none
module probe_model (
    input wire logic                    clk,        // Device clock.
    input wire logic                    rst_n,      // Sync reset, low.
    input wire logic                    link_valid, // Record on link.
    input wire swtrace_pkg::record_type link_rec,   // Record being sent.
    input wire logic                    link_done   // Record time over.
);
    timeunit 1ns;
    timeprecision 1ps;
    import swtrace_pkg::*;

    record_type rec_q[$]; // Records in arrival order.
    int         len_q[$]; // Cycles each record held the link.
    longint     ts_q[$];  // Stamp taken on arrival.
    longint     stamp_r;  // Stamp counter, one clock of resolution.
    int         len_r;    // Length of the record in flight.

    // The stamp runs from reset, so it is counting before any program can start.
    // The probe only listens, so it never touches memory or polls while tracing.
    // It has no path to the select field and plants no trap instruction either.
    always @(posedge clk) begin
        if (!rst_n) begin
            stamp_r <= 0;
            len_r <= 0;
        end else begin
            stamp_r <= stamp_r + 1;
            if (link_valid === 1'b1) begin
                len_r <= len_r + 1;
            end
            if (link_valid === 1'b1 && len_r == 0) begin
                ts_q.push_back(stamp_r);
                rec_q.push_back(link_rec);
            end
            if (link_done === 1'b1) begin
                len_q.push_back(len_r);
                len_r <= 0;
            end
        end
    end
endmodule : probe_model
`default_nettype wire

// file: testbench/test_software_trace_debug_port.sv
`default_nettype none
module test_software_trace_debug_port;
    timeunit 1ns;
    timeprecision 1ps;
    import swtrace_pkg::*;

    logic clk, rst_n, probe_on, link_1wire, slow_internal_osc, trace_used;
    logic insn_valid, prog_start, break_req, insn_ready, link_valid, link_done;
    logic overflow, break_out, ram_we;
    insn_type          insn;
    record_type        link_rec;
    logic [DATA_W-1:0] gpr_value;
    logic [REGN_W-1:0] gpr_index;
    logic [1:0]        debug_if_sel;
    logic [RAM_AW-1:0] ram_addr;
    logic [31:0]       ram_wdata;
    int num_errors = 0, cmp_count = 0, ram_cnt = 0, ram_bad = 0, ov_cnt = 0, lv_cnt = 0;

    // Register file stand-in: each value carries its own index.
    assign gpr_value = {16'hA5C3, 11'h000, gpr_index};

    // The 4-wire tag time keeps its real length, so it is judged against the package value.
    software_trace_debug_port #(.BLANK_FAST(20), .BLANK_SLOW(40), .LONG_4(8),
        .LONG_1(16), .SHORT_1(6)) DUT (.clk(clk), .rst_n(rst_n), .probe_on(probe_on),
        .link_1wire(link_1wire), .slow_internal_osc(slow_internal_osc),
        .trace_used(trace_used), .insn_valid(insn_valid), .insn(insn),
        .gpr_value(gpr_value), .prog_start(prog_start), .break_req(break_req),
        .insn_ready(insn_ready), .gpr_index(gpr_index), .link_valid(link_valid),
        .link_rec(link_rec), .link_done(link_done), .overflow(overflow),
        .debug_if_sel(debug_if_sel), .break_out(break_out), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata));

    probe_model probe (.clk(clk), .rst_n(rst_n), .link_valid(link_valid),
        .link_rec(link_rec), .link_done(link_done));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Event counters for pulses that the scenarios judge afterwards.
    always @(posedge clk) begin
        if (ram_we === 1'b1) begin
            ram_cnt <= ram_cnt + 1;
            ram_bad <= ram_bad + ((ram_wdata !== RAM_CLEAR ||
                                   ram_addr !== RAM_AW'(ram_cnt)) ? 1 : 0);
        end
        ov_cnt <= ov_cnt + ((overflow === 1'b1) ? 1 : 0);
        lv_cnt <= lv_cnt + ((link_valid === 1'b1) ? 1 : 0);
    end

    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask : chk

    // Waits for a quiet link; a hang counts as a mismatch and ends the run.
    task automatic settle();
        int q, n;
        q = 0;
        n = 0;
        while (q < 6 && n < 60000) begin
            @(posedge clk);
            n++;
            q = (insn_ready === 1'b1 && link_valid === 1'b0) ? q + 1 : 0;
        end
        if (n >= 60000) begin
            num_errors++;
            wrap_up();
        end
    endtask : settle

    // A full instruction is held for one edge only; busy issue is ignored, so wait first.
    task automatic issue(input insn_kind_type k, input logic wp, input logic [9:0] tg,
                         input logic [4:0] lo, input logic [4:0] hi, input logic [31:0] pc);
        int n;
        n = 0;
        // Ready is read at the falling edge, where the last rising edge has settled it.
        @(negedge clk);
        while (insn_ready !== 1'b1 && n < 60000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60000) begin
            num_errors++;
            wrap_up();
        end
        @(posedge clk);
        insn_valid <= 1'b1;
        insn <= '{kind: k, with_pc: wp, tag: tg, reg_lo: lo, reg_hi: hi, pc: pc};
        @(posedge clk);
        insn_valid <= 1'b0;
    endtask : issue

    task automatic exp_rec(input int i, input rec_kind_type k, input logic [4:0] rn,
                           input logic [31:0] v, input int len);
        if (i >= probe.len_q.size() || i >= probe.rec_q.size()) begin
            chk(probe.len_q.size() > i && probe.rec_q.size() > i, 1'b1);
            return;
        end
        chk(probe.rec_q[i].kind, k);
        if (k == REC_REG) begin
            chk(probe.rec_q[i].regnum, rn);
        end
        chk(probe.rec_q[i].value, v);
        chk(probe.len_q[i], len);
    endtask : exp_rec

    task automatic clr(input string s);
        $display("test %s done", s);
        probe.rec_q.delete();
        probe.len_q.delete();
        probe.ts_q.delete();
    endtask : clr

    task automatic t_connect();
        int n;
        n = 0;
        chk(debug_if_sel, SEL_NONE);
        probe_on <= 1'b1;
        while (ram_cnt < 4096 && n < 10000) begin
            @(posedge clk);
            n++;
        end
        settle();
        chk(ram_cnt, 4096);
        chk(ram_bad, 0);
        chk(debug_if_sel, SEL_4WIRE);
        clr("connect");
    endtask : t_connect

    // Three back-to-back PC records leave whole, in order, at 4-wire pace.
    task automatic t_pc();
        for (int i = 0; i < 3; i++) issue(INSN_PC, 1'b0, 10'h000, 5'h00, 5'h00, 32'hCAFE_0010 + i);
        settle();
        chk(probe.rec_q.size(), 3);
        for (int i = 0; i < 3; i++) exp_rec(i, REC_PC, 5'h00, 32'hCAFE_0010 + i, 8);
        chk(probe.ts_q[2] - probe.ts_q[1] >= 8, 1'b1);
        clr("pc");
    endtask : t_pc

    task automatic t_tag();
        link_1wire <= 1'b1;
        repeat (3) @(posedge clk);
        chk(debug_if_sel, SEL_1WIRE);
        issue(INSN_TAG, 1'b0, 10'h3A5, 5'h00, 5'h00, 32'h0000_1234);
        issue(INSN_TAG, 1'b1, 10'h2C1, 5'h00, 5'h00, 32'h0000_5678);
        settle();
        exp_rec(0, REC_TAG, 5'h00, 32'h0000_03A5, 6);
        exp_rec(1, REC_TAG, 5'h00, 32'h0000_02C1, 6);
        exp_rec(2, REC_PC, 5'h00, 32'h0000_5678, 16);
        link_1wire <= 1'b0;
        issue(INSN_TAG, 1'b0, 10'h155, 5'h00, 5'h00, 32'h0000_0000);
        settle();
        exp_rec(3, REC_TAG, 5'h00, 32'h0000_0155, CYC_4_SHORT);
        clr("tag");
    endtask : t_tag

    task automatic t_reg();
        issue(INSN_REG, 1'b1, 10'h000, 5'h03, 5'h06, 32'h0000_9ABC);
        settle();
        for (int r = 3; r <= 6; r++) exp_rec(r - 3, REC_REG, r, {16'hA5C3, 11'h000, 5'(r)}, 8);
        exp_rec(4, REC_PC, 5'h00, 32'h0000_9ABC, 8);
        clr("reg");
    endtask : t_reg

    // Naming all 32 registers breaks the software limit on purpose to fill the buffer.
    task automatic t_over();
        int o;
        o = ov_cnt;
        issue(INSN_REG, 1'b0, 10'h000, 5'h00, 5'h1F, 32'h0000_0000);
        settle();
        chk(ov_cnt != o, 1'b1);
        chk(probe.rec_q.size() + ov_cnt - o, 32);
        chk(probe.rec_q.size() >= BUF_DEPTH, 1'b1);
        // The first full buffer leaves intact; later survivors keep ascending order and matching values.
        for (int i = 0; i < BUF_DEPTH; i++) begin
            exp_rec(i, REC_REG, 5'(i), {16'hA5C3, 11'h000, 5'(i)}, 8);
        end
        for (int i = BUF_DEPTH; i < probe.rec_q.size(); i++) begin
            chk(probe.rec_q[i].regnum > probe.rec_q[i-1].regnum, 1'b1);
            chk(probe.rec_q[i].value, {16'hA5C3, 11'h000, probe.rec_q[i].regnum});
        end
        clr("overflow");
    endtask : t_over

    task automatic t_noprobe();
        int l;
        probe_on <= 1'b0;
        repeat (3) @(posedge clk);
        l = lv_cnt;
        issue(INSN_PC, 1'b0, 10'h000, 5'h00, 5'h00, 32'h0000_0BAD);
        repeat (40) @(posedge clk);
        chk(lv_cnt - l, 0);
        clr("no probe");
    endtask : t_noprobe

    task automatic t_blank(input logic slow, input int bl);
        int n;
        trace_used <= 1'b0;
        slow_internal_osc <= slow;
        break_req <= 1'b1;
        prog_start <= 1'b1;
        @(posedge clk);
        prog_start <= 1'b0;
        n = 0;
        while (break_out !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(n >= bl && n <= bl + 3, 1'b1);
        break_req <= 1'b0;
        repeat (4) @(posedge clk);
        clr("blanking");
    endtask : t_blank

    initial begin
        rst_n = 1'b0;
        probe_on = 1'b0;
        link_1wire = 1'b0;
        slow_internal_osc = 1'b0;
        trace_used = 1'b1;
        insn_valid = 1'b0;
        insn = '0;
        prog_start = 1'b0;
        break_req = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_connect();
        t_pc();
        t_tag();
        t_reg();
        t_over();
        t_noprobe();
        t_blank(1'b0, 20);
        t_blank(1'b1, 40);
        wrap_up();
    end
endmodule : test_software_trace_debug_port
`default_nettype wire
